/* File: design/itxcs_pkg.sv */
// Package: constants, types and register map of the iso transmit status block
package itxcs_pkg;

    localparam int unsigned ITXCS_NUM_CTX = 8;
    localparam int unsigned ITXCS_ADDR_W = 12;

    // Register map, byte addresses, context stride 16 bytes; pointer load slots 4 bytes apart
    localparam logic [11:0] ITXCS_CTL_SET_BASE = 12'h200;
    localparam logic [11:0] ITXCS_CTL_CLR_BASE = 12'h204;
    localparam logic [11:0] ITXCS_CMD_PTR_BASE = 12'h20c;
    localparam logic [11:0] ITXCS_CTX_STRIDE = 12'h010;
    localparam logic [11:0] ITXCS_INT_STAT_ADDR = 12'h300;
    localparam logic [11:0] ITXCS_INT_MASK_ADDR = 12'h304;
    localparam logic [11:0] ITXCS_PTR_LOAD_BASE = 12'h308;

    // Control register field positions
    localparam int unsigned ITXCS_RUN_BIT = 15;
    localparam int unsigned ITXCS_WAKE_BIT = 12;
    localparam int unsigned ITXCS_DEAD_BIT = 11;
    localparam int unsigned ITXCS_ACTIVE_BIT = 10;
    localparam int unsigned ITXCS_SPD_LSB = 5;
    localparam int unsigned ITXCS_EVT_LSB = 0;

    // Completion codes
    localparam logic [4:0] ITXCS_EVT_NONE = 5'h00;
    localparam logic [4:0] ITXCS_EVT_TIMEOUT = 5'h0a;
    localparam logic [4:0] ITXCS_EVT_DESC_READ = 5'h05;
    localparam logic [4:0] ITXCS_EVT_DATA_READ = 5'h07;
    localparam logic [4:0] ITXCS_EVT_UNKNOWN = 5'h0e;
    localparam logic [4:0] ITXCS_ACK_COMPLETE = 5'h11;

    localparam logic [2:0] ITXCS_MAX_SKIPS = 3'h7;
    localparam logic [31:0] ITXCS_ZERO32 = 32'h0000_0000;

    typedef enum logic [1:0]
    {
        ITXCS_OUT_OK,
        ITXCS_OUT_DESC_ERR,
        ITXCS_OUT_DATA_ERR,
        ITXCS_OUT_UNKNOWN
    } itxcs_outcome_type;

    // One context's status fields
    typedef struct packed
    {
        logic run;
        logic wake;
        logic dead;
        logic active;
        logic [4:0] evt;
        logic [2:0] skips;
    } itxcs_ctx_type;

    // Events from the descriptor engine for one context
    typedef struct packed
    {
        logic fetch;
        logic fatal;
        logic last_done;
        itxcs_outcome_type outcome;
        logic overflow;
        logic cycle_sent;
    } itxcs_evt_type;

endpackage

/* File: design/itxcs_ptr_mem.sv */
// Command pointer storage, one word per context, registered read
module itxcs_ptr_mem
    import itxcs_pkg::*;
#(
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW = 3
)
(
    input wire logic clk,
    input wire logic ce,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [31:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [31:0] rdata
);

    logic [31:0] mem [DEPTH];

    // No reset: contents are undefined until software loads a pointer
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (we)
            begin
                mem[waddr] <= wdata;
            end
            rdata <= mem[raddr];
        end
    end

endmodule

/* File: design/itxcs_ctx.sv */
// Status state of one isochronous transmit context
module itxcs_ctx
    import itxcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic run_set,
    input wire logic run_clr,
    input wire logic wake_set,
    input wire itxcs_evt_type evt,
    output itxcs_ctx_type st,
    output logic start,
    output logic skip_fault
);

    typedef struct packed
    {
        itxcs_ctx_type c;
        logic start;
        logic skip_fault;
    } itxcs_ctxstate_type;

    itxcs_ctxstate_type s_q;
    itxcs_ctxstate_type s_d;

    always_comb
    begin
        s_d = s_q;
        s_d.start = 1'b0;
        s_d.skip_fault = 1'b0;
        if (run_set && !s_q.c.run)
        begin
            s_d.c.run = 1'b1;
            s_d.start = 1'b1;
        end
        if (run_clr)
        begin
            s_d.c.run = 1'b0;
            s_d.c.dead = 1'b0;
            s_d.c.active = 1'b0;
            s_d.c.skips = 3'h0;
        end
        else if (s_q.c.run && !s_q.c.dead)
        begin
            if (s_q.start || (s_q.c.wake && !s_q.c.active))
            begin
                s_d.c.active = 1'b1;
            end
            if (evt.last_done)
            begin
                case (evt.outcome)
                    ITXCS_OUT_OK: s_d.c.evt = ITXCS_ACK_COMPLETE;
                    ITXCS_OUT_DESC_ERR: s_d.c.evt = ITXCS_EVT_DESC_READ;
                    ITXCS_OUT_DATA_ERR: s_d.c.evt = ITXCS_EVT_DATA_READ;
                    default: s_d.c.evt = ITXCS_EVT_UNKNOWN;
                endcase
            end
            if (evt.cycle_sent)
            begin
                s_d.c.skips = 3'h0;
            end
            else if (evt.overflow)
            begin
                if (s_q.c.skips == ITXCS_MAX_SKIPS)
                begin
                    s_d.c.dead = 1'b1;
                    s_d.c.evt = ITXCS_EVT_TIMEOUT;
                    s_d.c.active = 1'b0;
                    s_d.skip_fault = 1'b1;
                end
                else
                begin
                    s_d.c.skips = s_q.c.skips + 3'h1;
                end
            end
            if (evt.fatal)
            begin
                s_d.c.dead = 1'b1;
                s_d.c.active = 1'b0;
            end
        end
        // Fetch clears wake; a new wake in the same cycle survives
        if (evt.fetch)
        begin
            s_d.c.wake = 1'b0;
        end
        if (wake_set)
        begin
            s_d.c.wake = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_q <= '0;
        end
        else if (ce)
        begin
            s_q <= s_d;
        end
    end

    assign st = s_q.c;
    assign start = s_q.start;
    assign skip_fault = s_q.skip_fault;

endmodule

/* File: design/itxcs_top.sv */
// Top: register slave, contexts, command pointers and interrupt
//
// The address-and-strobe port is this design's own decision.
module itxcs_top
    import itxcs_pkg::*;
#(
    parameter int unsigned NUM_CTX = ITXCS_NUM_CTX
)
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    input wire itxcs_evt_type [NUM_CTX-1:0] ENG_EVT,
    output logic [NUM_CTX-1:0] ENG_START,
    output logic [NUM_CTX-1:0] ENG_RUN,
    output logic [31:0] ENG_PTR,
    output logic ENG_PTR_VALID,
    output logic UNRECOVERABLE_FAULT,
    output logic IRQ
);

    localparam int unsigned CW = $clog2(NUM_CTX);

    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    // Decode of a per-context slot: returns one-hot hit for a base
    function automatic logic [NUM_CTX-1:0] slot_hit(
        input logic [11:0] addr,
        input logic [11:0] base
    );
        logic [NUM_CTX-1:0] h;
        h = '0;
        for (int i = 0; i < NUM_CTX; i++)
        begin
            if (addr == base + 12'(i) * ITXCS_CTX_STRIDE)
            begin
                h[i] = 1'b1;
            end
        end
        return h;
    endfunction

    function automatic logic [CW-1:0] ctx_of(input logic [11:0] addr);
        return CW'(addr[11:4] - ITXCS_CMD_PTR_BASE[11:4]);
    endfunction

    // Pointer load slots are word spaced from their base; no hit outside
    function automatic logic [NUM_CTX-1:0] load_hit(
        input logic [11:0] addr
    );
        logic [11:0] off;
        logic [NUM_CTX-1:0] h;
        off = addr - ITXCS_PTR_LOAD_BASE;
        h = '0;
        for (int i = 0; i < NUM_CTX; i++)
        begin
            if (off == 12'(i) << 2)
            begin
                h[i] = 1'b1;
            end
        end
        return h;
    endfunction

    // Index of the set bit of a one-hot slot vector, zero when none
    function automatic logic [CW-1:0] onehot_idx(
        input logic [NUM_CTX-1:0] h
    );
        logic [CW-1:0] idx;
        idx = '0;
        for (int i = 0; i < NUM_CTX; i++)
        begin
            if (h[i])
            begin
                idx = CW'(i);
            end
        end
        return idx;
    endfunction

    // Interrupt status bits: per context halted, per context completion
    typedef struct packed
    {
        logic [31:0] rdata;
        logic [1:0] rsel;
        logic [NUM_CTX-1:0] halt_stat;
        logic [NUM_CTX-1:0] done_stat;
        logic [NUM_CTX-1:0] halt_mask;
        logic [NUM_CTX-1:0] done_mask;
        logic fault;
        logic ptr_valid;
    } itxcs_top_type;

    localparam logic [1:0] SEL_REG = 2'h0;
    localparam logic [1:0] SEL_PTR = 2'h1;

    itxcs_top_type s_q;
    itxcs_top_type s_d;

    itxcs_ctx_type [NUM_CTX-1:0] ctx_st;
    logic [NUM_CTX-1:0] ctx_start;
    logic [NUM_CTX-1:0] ctx_skip;
    logic [NUM_CTX-1:0] hit_set;
    logic [NUM_CTX-1:0] hit_clr;
    logic [NUM_CTX-1:0] hit_ptr;
    logic [NUM_CTX-1:0] hit_load;
    logic [CW-1:0] load_ctx;
    logic [NUM_CTX-1:0] run_set;
    logic [NUM_CTX-1:0] run_clr;
    logic [NUM_CTX-1:0] wake_set;
    logic [31:0] mem_rdata;
    logic [CW-1:0] mem_raddr;
    logic [CW-1:0] start_sel;
    logic any_start;

    // ---------------------------------------------------------------
    // Address decode
    // ---------------------------------------------------------------
    assign hit_set = slot_hit(ADDR, ITXCS_CTL_SET_BASE);
    assign hit_clr = slot_hit(ADDR, ITXCS_CTL_CLR_BASE);
    assign hit_ptr = slot_hit(ADDR, ITXCS_CMD_PTR_BASE);
    // Load window crosses an address row; decode by offset from its base
    assign hit_load = load_hit(ADDR);
    assign load_ctx = onehot_idx(hit_load);

    // ---------------------------------------------------------------
    // Contexts
    // ---------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_CTX; g++)
        begin : gen_ctx
            assign run_set[g] = WR && hit_set[g] && WDATA[ITXCS_RUN_BIT];
            assign run_clr[g] = WR && hit_clr[g] && WDATA[ITXCS_RUN_BIT];
            assign wake_set[g] = WR && hit_set[g] && WDATA[ITXCS_WAKE_BIT];
            itxcs_ctx u_ctx
            (
                .clk(CLK),
                .rst_b(RST_B),
                .ce(CE),
                .run_set(run_set[g]),
                .run_clr(run_clr[g]),
                .wake_set(wake_set[g]),
                .evt(ENG_EVT[g]),
                .st(ctx_st[g]),
                .start(ctx_start[g]),
                .skip_fault(ctx_skip[g])
            );
            assign ENG_RUN[g] = ctx_st[g].run;
        end
    endgenerate

    // Lowest started context wins the pointer port this cycle
    always_comb
    begin
        start_sel = '0;
        any_start = 1'b0;
        for (int i = NUM_CTX - 1; i >= 0; i--)
        begin
            if (ctx_start[i])
            begin
                start_sel = CW'(i);
                any_start = 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Pointer storage
    // ---------------------------------------------------------------

    // A software command pointer read has the memory port; pointer fetch uses the other cycles.
    // Limitation: starts in the same cycle on several contexts are not serialised;
    // only the lowest started context's pointer is read in that start cycle and goes out in the next.
    assign mem_raddr = (RD && |hit_ptr) ? ctx_of(ADDR) : start_sel;

    itxcs_ptr_mem #(.DEPTH(NUM_CTX), .AW(CW)) u_mem
    (
        .clk(CLK),
        .ce(CE),
        .we(WR && |hit_load),
        .waddr(load_ctx),
        .wdata(WDATA),
        .raddr(mem_raddr),
        .rdata(mem_rdata)
    );

    // ---------------------------------------------------------------
    // Register slave and interrupt
    // ---------------------------------------------------------------
    always_comb
    begin
        s_d = s_q;
        s_d.rsel = SEL_REG;
        s_d.rdata = ITXCS_ZERO32;
        // Pointer word is read in the start cycle and handed over next;
        // a colliding pointer read takes the port and drops the handover
        s_d.ptr_valid = any_start && !(RD && |hit_ptr);
        if (RD)
        begin
            for (int i = 0; i < NUM_CTX; i++)
            begin
                if (hit_set[i] || hit_clr[i])
                begin
                    s_d.rdata[ITXCS_RUN_BIT] = ctx_st[i].run;
                    s_d.rdata[ITXCS_WAKE_BIT] = ctx_st[i].wake;
                    s_d.rdata[ITXCS_DEAD_BIT] = ctx_st[i].dead;
                    s_d.rdata[ITXCS_ACTIVE_BIT] = ctx_st[i].active;
                    // Unused bits and speed field stay zero
                    s_d.rdata[ITXCS_EVT_LSB +: 5] = ctx_st[i].evt;
                end
            end
            if (|hit_ptr)
            begin
                s_d.rsel = SEL_PTR;
            end
            if (ADDR == ITXCS_INT_STAT_ADDR)
            begin
                s_d.rdata = {16'h0000, s_q.halt_stat, s_q.done_stat};
            end
            if (ADDR == ITXCS_INT_MASK_ADDR)
            begin
                s_d.rdata = {16'h0000, s_q.halt_mask, s_q.done_mask};
            end
        end
        if (WR && ADDR == ITXCS_INT_STAT_ADDR)
        begin
            s_d.done_stat = s_q.done_stat & ~WDATA[NUM_CTX-1:0];
            s_d.halt_stat = s_q.halt_stat & ~WDATA[2*NUM_CTX-1:NUM_CTX];
            s_d.fault = 1'b0;
        end
        if (WR && ADDR == ITXCS_INT_MASK_ADDR)
        begin
            s_d.done_mask = WDATA[NUM_CTX-1:0];
            s_d.halt_mask = WDATA[2*NUM_CTX-1:NUM_CTX];
        end
        // Set wins over a clear in the same cycle
        for (int i = 0; i < NUM_CTX; i++)
        begin
            if (ENG_EVT[i].last_done && ctx_st[i].run)
            begin
                s_d.done_stat[i] = 1'b1;
            end
            if ((ENG_EVT[i].fatal || ctx_skip[i]) && ctx_st[i].run)
            begin
                s_d.halt_stat[i] = 1'b1;
            end
            if (ctx_skip[i])
            begin
                s_d.fault = 1'b1;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            s_q <= '0;
        end
        else if (CE)
        begin
            s_q <= s_d;
        end
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------

    assign RDATA = (s_q.rsel == SEL_PTR) ? mem_rdata : s_q.rdata;
    // Pointer bus reads zero outside its handover cycle
    assign ENG_PTR = s_q.ptr_valid ? mem_rdata : ITXCS_ZERO32;
    assign ENG_PTR_VALID = s_q.ptr_valid;
    assign ENG_START = ctx_start;
    assign UNRECOVERABLE_FAULT = s_q.fault;
    // Level interrupt: any unmasked sticky bit
    assign IRQ = |((s_q.done_stat & s_q.done_mask) |
        (s_q.halt_stat & s_q.halt_mask));

endmodule

/* File: bench/itxcs_eng_model.sv */
// Partner model: descriptor engine stand-in driving per-context events
module itxcs_eng_model
    import itxcs_pkg::*;
#(
    parameter int unsigned N = 8
)
(
    input wire logic clk,
    input wire logic [N-1:0] start,
    input wire logic ptr_valid,
    output itxcs_evt_type [N-1:0] evt
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [N-1:0] pend_q = '0;
    logic [N-1:0] fetch_q = '0;
    itxcs_evt_type [N-1:0] cmd = '0;

    // First block is fetched only once the pointer has been handed over
    always @(posedge clk)
    begin
        if (|start)
            pend_q <= start;
        fetch_q <= ptr_valid ? pend_q : '0;
    end

    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            evt[i] = cmd[i];
            evt[i].fetch = cmd[i].fetch | fetch_q[i];
        end
    end

    // One-cycle event pulse; a clock edge always separates two pulses
    task automatic pulse(input int c, input itxcs_evt_type e);
        @(posedge clk);
        cmd[c] <= e;
        @(posedge clk);
        cmd[c] <= '0;
    endtask
endmodule

/* File: bench/itxcs_top_assertions.sv */
// Checker: port-level assertions for the iso transmit status block
module itxcs_top_assertions
    import itxcs_pkg::*;
#(
    parameter int unsigned NUM_CTX = ITXCS_NUM_CTX
)
(
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CE,
    input wire logic [11:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [31:0] RDATA,
    input wire itxcs_evt_type [NUM_CTX-1:0] ENG_EVT,
    input wire logic [NUM_CTX-1:0] ENG_START,
    input wire logic [NUM_CTX-1:0] ENG_RUN,
    input wire logic [31:0] ENG_PTR,
    input wire logic ENG_PTR_VALID,
    input wire logic UNRECOVERABLE_FAULT,
    input wire logic IRQ
);
    logic ovf_any;

    always_comb
    begin
        ovf_any = 1'b0;
        for (int i = 0; i < NUM_CTX; i++)
        begin
            ovf_any = ovf_any | ENG_EVT[i].overflow;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_B);

    // ------------------------------------------------
    // Start sequence
    // ------------------------------------------------
    sequence s_run_set;
        CE && WR && ADDR == ITXCS_CTL_SET_BASE && WDATA[ITXCS_RUN_BIT]
            && !ENG_RUN[0];
    endsequence

    sequence s_start_ptr;
        ENG_START[0] ##1 ENG_PTR_VALID;
    endsequence

    // Start pulse the cycle after the write, pointer handed over next
    a_start_after_run: assert property (
        s_run_set |=> s_start_ptr)
        else $error("run set did not start the context");
    a_ptr_zero_idle: assert property (
        !ENG_PTR_VALID |-> ENG_PTR == ITXCS_ZERO32)
        else $error("pointer not zero while invalid");
    a_unused_zero: assert property (
        $past(RD) && $past(ADDR[11:7]) == 5'h04 && !$past(ADDR[3])
        |-> RDATA[14:13] == 2'h0 && RDATA[9:5] == 5'h00)
        else $error("unused control bits read nonzero");
    a_rdata_idle: assert property (
        RDATA != ITXCS_ZERO32 |-> $past(RD))
        else $error("read data outside read answer cycle");
    a_run_sw_only: assert property (
        $changed(ENG_RUN) |-> $past(WR))
        else $error("run changed without a write");
    a_run_clear: assert property (
        CE && WR && ADDR == ITXCS_CTL_CLR_BASE && WDATA[ITXCS_RUN_BIT]
        |=> !ENG_RUN[0])
        else $error("run clear write ignored");
    a_fault_hold: assert property (
        UNRECOVERABLE_FAULT && !(WR && ADDR == ITXCS_INT_STAT_ADDR)
        |=> UNRECOVERABLE_FAULT)
        else $error("fault dropped without a clear");
    // A skip halt from an overflow in the cycle before wins over the clear
    a_fault_clear: assert property (
        CE && WR && ADDR == ITXCS_INT_STAT_ADDR && !$past(ovf_any)
        |=> !UNRECOVERABLE_FAULT)
        else $error("fault not cleared");
    // Halt pulse is one register stage after overflow, fault flag two
    a_fault_cause: assert property (
        $rose(UNRECOVERABLE_FAULT) |-> $past(ovf_any, 2))
        else $error("fault without an overflow");
endmodule

bind itxcs_top itxcs_top_assertions #(.NUM_CTX(NUM_CTX)) u_chk (.CLK(CLK),
    .RST_B(RST_B), .CE(CE), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .ENG_EVT(ENG_EVT), .ENG_START(ENG_START),
    .ENG_RUN(ENG_RUN), .ENG_PTR(ENG_PTR), .ENG_PTR_VALID(ENG_PTR_VALID),
    .UNRECOVERABLE_FAULT(UNRECOVERABLE_FAULT), .IRQ(IRQ));

/* File: bench/tb_itxcs_top.sv */
// Testbench: register-level scenarios for the iso transmit status block
module tb_itxcs_top
    import itxcs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic ce = 1'b1;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [11:0] addr = '0;
    logic [31:0] wdata = '0;
    logic [31:0] rdata;
    logic [31:0] d;
    itxcs_evt_type [7:0] eng_evt;
    logic [7:0] eng_start;
    logic [7:0] eng_run;
    logic [31:0] eng_ptr;
    logic eng_ptr_valid;
    logic fault;
    logic irq;
    logic ok;
    logic [4:0] codes [4] = '{5'h11, 5'h05, 5'h07, 5'h0e};
    int err_count = 0;
    int checks_done = 0;

    always #5 clk = ~clk;

    itxcs_top #(.NUM_CTX(8)) dut (.CLK(clk), .RST_B(rst_b), .CE(ce),
        .ADDR(addr), .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
        .ENG_EVT(eng_evt), .ENG_START(eng_start), .ENG_RUN(eng_run),
        .ENG_PTR(eng_ptr), .ENG_PTR_VALID(eng_ptr_valid),
        .UNRECOVERABLE_FAULT(fault), .IRQ(irq));

    itxcs_eng_model #(.N(8)) eng (.clk(clk), .start(eng_start),
        .ptr_valid(eng_ptr_valid), .evt(eng_evt));

    // ------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr_s <= 1'b1;
        @(posedge clk);
        wr_s <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [11:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        v = rdata;
    endtask

    task automatic cmp32(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
        end
    endtask

    task automatic cmp1(input logic g, input logic e);
        checks_done++;
        if (g !== e)
        begin
            err_count++;
            $display("MISMATCH t=%0t flag %b exp %b", $time, g, e);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    initial
    begin
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        rd(ITXCS_CTL_SET_BASE, d);
        cmp32(d, 32'h0000_0000);
        rd(12'h3f0, d);
        cmp32(d, 32'h0000_0000);
        wr(ITXCS_PTR_LOAD_BASE, 32'h1234_5670);
        wr(12'h324, 32'h0abc_def0);
        wr(12'h27c, 32'hffff_ffff);
        rd(12'h27c, d);
        cmp32(d, 32'h0abc_def0);
        wr(ITXCS_CTL_SET_BASE, 32'h0000_8000);
        // Start pulse already stands when the write task returns
        ok = (eng_start[0] === 1'b1);
        for (int i = 0; i < 20 && !ok; i++)
        begin
            @(posedge clk);
            #1;
            ok = (eng_start[0] === 1'b1);
        end
        if (!ok)
        begin
            err_count++;
            $display("MISMATCH t=%0t no start", $time);
            complete_run();
        end
        @(posedge clk);
        #1;
        cmp1(eng_ptr_valid, 1'b1);
        cmp32(eng_ptr, 32'h1234_5670);
        cmp1(eng_run[0], 1'b1);
        rd(ITXCS_CTL_SET_BASE, d);
        cmp32(d, 32'h0000_8400);
        rd(ITXCS_CMD_PTR_BASE, d);
        cmp32(d, 32'h1234_5670);
        wr(ITXCS_CTL_SET_BASE, 32'h0000_1000);
        rd(ITXCS_CTL_SET_BASE, d);
        cmp32(d, 32'h0000_9400);
        eng.pulse(0, 7'h40);
        rd(ITXCS_CTL_SET_BASE, d);
        cmp32(d, 32'h0000_8400);
        for (int k = 0; k < 4; k++)
        begin
            eng.pulse(0, {3'h1, 2'(k), 2'h0});
            rd(ITXCS_CTL_SET_BASE, d);
            cmp32(d & 32'h0000_001f, {27'h0, codes[k]});
        end
        eng.pulse(0, 7'h20);
        rd(ITXCS_CTL_SET_BASE, d);
        cmp32(d, 32'h0000_880e);
        cmp1(irq, 1'b0);
        rd(ITXCS_INT_STAT_ADDR, d);
        cmp32(d & 32'h0000_0100, 32'h0000_0100);
        wr(ITXCS_INT_MASK_ADDR, 32'h0000_0100);
        cmp1(irq, 1'b1);
        // Completion while halted must leave the posted code alone
        eng.pulse(0, 7'h10);
        rd(ITXCS_CTL_SET_BASE, d);
        cmp32(d & 32'h0000_001f, 32'h0000_000e);
        wr(ITXCS_INT_STAT_ADDR, 32'h0000_0100);
        cmp1(irq, 1'b0);
        wr(ITXCS_CTL_CLR_BASE, 32'h0000_8000);
        rd(ITXCS_CTL_SET_BASE, d);
        cmp32(d & 32'h0000_ffe0, 32'h0000_0000);
        cmp1(eng_run[0], 1'b0);
        wr(ITXCS_CTL_SET_BASE, 32'h0000_8000);
        repeat (7) eng.pulse(0, 7'h02);
        eng.pulse(0, 7'h01);
        repeat (7) eng.pulse(0, 7'h02);
        cmp1(fault, 1'b0);
        eng.pulse(0, 7'h02);
        // Fault flag follows the context's halt pulse by one register
        @(posedge clk);
        #1;
        cmp1(fault, 1'b1);
        rd(ITXCS_CTL_SET_BASE, d);
        cmp32(d, 32'h0000_880a);
        wr(ITXCS_INT_STAT_ADDR, 32'hffff_ffff);
        cmp1(fault, 1'b0);
        // Frozen block ignores a run clear write
        @(posedge clk);
        ce <= 1'b0;
        wr(ITXCS_CTL_CLR_BASE, 32'h0000_8000);
        @(posedge clk);
        ce <= 1'b1;
        rd(ITXCS_CTL_SET_BASE, d);
        cmp32(d, 32'h0000_880a);
        complete_run();
    end
endmodule
